//--- src/plc_timer_pkg.sv
package plc_timer_pkg;

	localparam int          NUM_TIMERS = 512;
	localparam int          IDX_W      = 9;
	localparam int          IN_W       = 6;
	localparam int unsigned CLK_HZ     = 50_000_000;
	localparam int unsigned TICK_MS    = 1;
	localparam int unsigned TICK_CYC   = CLK_HZ / 1000 * TICK_MS;

	// Input vector bit positions
	localparam int IN_ENABLE  = 0;
	localparam int IN_RESET   = 1;
	localparam int IN_ONESHOT = 2;
	localparam int IN_DLY_ON  = 3;
	localparam int IN_DLY_OFF = 4;
	localparam int IN_LIMIT   = 5;
	localparam logic [IN_W-1:0] IN_RST_VAL = 6'h01;
	localparam logic [IN_W-1:0] TRIG_MASK  = 6'h3C;

	// Status register bit positions
	localparam int ST_STATUS = 0;
	localparam int ST_RUN    = 1;
	localparam int ST_DELAY  = 2;

	// Register byte offsets
	localparam logic [4:0] REG_SELECT  = 5'h00;
	localparam logic [4:0] REG_CONST   = 5'h04;
	localparam logic [4:0] REG_INPUTS  = 5'h08;
	localparam logic [4:0] REG_STATUS  = 5'h0C;
	localparam logic [4:0] REG_ELAPSED = 5'h10;
	localparam logic [4:0] REG_ACTIVE  = 5'h14;

	localparam logic [31:0]      ZERO32   = 32'h0;
	localparam logic [IDX_W-1:0] IDX_STEP = 9'h001;
	localparam logic [IDX_W-1:0] IDX_LAST = 9'h1FF;

	typedef enum logic [1:0] {
		MODE_ONESHOT = 2'b01,
		MODE_DLY_ON  = 2'b10
	} timer_mode_t;

endpackage : plc_timer_pkg

//--- src/plc_timer_array.sv
`timescale 1ns/100ps
`default_nettype none
module plc_timer_array
	import plc_timer_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_CYC
) (
	input  wire logic        sys_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        ce_i,
	input  wire logic [4:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o
);

	////////////////////////////////////////////////////////////////////////
	// Byte-lane merge for bus writes
	function automatic logic [31:0] be_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	////////////////////////////////////////////////////////////////////////
	// Per-timer storage
	logic [IN_W-1:0]  in_mem      [NUM_TIMERS];
	logic [IN_W-1:0]  prev_mem    [NUM_TIMERS];
	logic [31:0]      const_mem   [NUM_TIMERS];
	logic [31:0]      elapsed_mem [NUM_TIMERS];
	logic             run_mem     [NUM_TIMERS];
	logic             stat_mem    [NUM_TIMERS];
	timer_mode_t      mode_mem    [NUM_TIMERS];

	logic [IDX_W-1:0] scan_idx;
	logic [IDX_W-1:0] last_idx;
	logic [IDX_W-1:0] sel;
	logic [31:0]      const_stage;
	logic [31:0]      tick_cnt;
	logic             tick_pend;
	logic             sweep_adv;

	logic [IN_W-1:0]  cur_lvl;
	logic [IN_W-1:0]  rise;
	logic [IN_W-1:0]  fall;
	logic [31:0]      cur_const;
	logic [31:0]      cur_el;
	logic [31:0]      ne;
	logic             cur_run;
	logic             cur_stat;
	timer_mode_t      cur_mode;
	logic             start_ok;
	logic             rst_edge;
	logic             next_run;
	logic             next_stat;
	timer_mode_t      next_mode;
	logic [31:0]      next_el;
	logic [IN_W-1:0]  next_prev;

	logic             bus_req;
	logic             conflict;
	logic             go;
	logic             wr_inputs;
	logic [IN_W-1:0]  wr_lvl;
	logic [IN_W-1:0]  sel_lvl;
	logic [31:0]      wr_word;
	logic [31:0]      sel_word;

	////////////////////////////////////////////////////////////////////////
	// Millisecond tick; one sweep of all timers takes far less than 1 ms
	// millisecond tick
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tick_cnt  <= ZERO32;
			tick_pend <= 1'b0;
			sweep_adv <= 1'b0;
		end else if (ce_i) begin
			if (tick_cnt == 32'(TICK_DIV - 1)) begin
				tick_cnt <= ZERO32;
			end else begin
				tick_cnt <= tick_cnt + 32'h1;
			end
			// A tick landing in the consume cycle is kept for the next sweep
			if (tick_cnt == 32'(TICK_DIV - 1)) begin
				tick_pend <= 1'b1;
			end else if (scan_idx == IDX_LAST) begin
				tick_pend <= 1'b0;
			end
			if (scan_idx == IDX_LAST) begin
				sweep_adv <= tick_pend;
			end
		end
	end

	// Round-robin scan pointer, one timer per cycle
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			scan_idx <= '0;
			last_idx <= '0;
		end else if (ce_i) begin
			scan_idx <= scan_idx + IDX_STEP;
			last_idx <= scan_idx;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Evaluation of the timer under the scan pointer
	always_comb begin
		cur_lvl   = in_mem[scan_idx];
		cur_const = const_mem[scan_idx];
		cur_el    = elapsed_mem[scan_idx];
		cur_run   = run_mem[scan_idx];
		cur_stat  = stat_mem[scan_idx];
		cur_mode  = mode_mem[scan_idx];
		rise      = cur_lvl & ~prev_mem[scan_idx];
		fall      = ~cur_lvl & prev_mem[scan_idx];
		rst_edge  = rise[IN_RESET];
		start_ok  = cur_lvl[IN_ENABLE] & ~cur_lvl[IN_RESET];
		ne        = cur_el + {31'h0, sweep_adv & cur_lvl[IN_ENABLE]};
		next_run  = cur_run;
		next_stat = cur_stat;
		next_mode = cur_mode;
		next_el   = cur_el;
		next_prev = cur_lvl;
		if (rst_edge) begin
			next_run  = 1'b0;
			next_stat = 1'b0;
			next_el   = ZERO32;
			next_prev = cur_lvl & ~TRIG_MASK;
		end else if (cur_run) begin
			if (cur_mode == MODE_DLY_ON && fall[IN_DLY_ON]) begin
				next_run  = 1'b0;
				next_stat = 1'b0;
			end else begin
				next_el = ne;
				if (ne >= cur_const) begin
					next_run  = 1'b0;
					next_stat = (cur_mode == MODE_DLY_ON);
				end
			end
		end else begin
			if (cur_stat && cur_mode == MODE_DLY_ON && fall[IN_DLY_ON]) begin
				next_stat = 1'b0;
			end
			if (start_ok && rise[IN_ONESHOT]) begin
				next_mode = MODE_ONESHOT;
				next_el   = ZERO32;
				next_run  = (cur_const != ZERO32);
				next_stat = (cur_const != ZERO32);
			end else if (start_ok && rise[IN_DLY_ON]) begin
				next_mode = MODE_DLY_ON;
				next_el   = ZERO32;
				next_run  = (cur_const != ZERO32);
				next_stat = (cur_const == ZERO32);
			end
		end
	end

	// Write back the scanned timer
	// per-timer state
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < NUM_TIMERS; i++) begin
				prev_mem[i]    <= IN_RST_VAL;
				elapsed_mem[i] <= ZERO32;
				run_mem[i]     <= 1'b0;
				stat_mem[i]    <= 1'b0;
				mode_mem[i]    <= MODE_ONESHOT;
			end
		end else if (ce_i) begin
			prev_mem[scan_idx]    <= next_prev;
			elapsed_mem[scan_idx] <= next_el;
			run_mem[scan_idx]     <= next_run;
			stat_mem[scan_idx]    <= next_stat;
			mode_mem[scan_idx]    <= next_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus request decode; an input write to the timer being scanned waits
	// one cycle so the scanner and the bus never touch the same entry
	always_comb begin
		bus_req   = ce_i & (avs_read_i | avs_write_i) & avs_waitrequest_o;
		conflict  = avs_write_i & (avs_address_i == REG_INPUTS)
			& (sel == scan_idx);
		go        = bus_req & ~conflict;
		wr_inputs = go & avs_write_i & (avs_address_i == REG_INPUTS);
		sel_lvl   = in_mem[sel];
		wr_word   = be_merge({26'h0, sel_lvl}, avs_writedata_i,
			avs_byteenable_i);
		wr_lvl    = wr_word[IN_W-1:0];
		sel_word  = be_merge({23'h0, sel}, avs_writedata_i,
			avs_byteenable_i);
	end

	// Input levels; enable defaults to 1 and reset to 0
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < NUM_TIMERS; i++) begin
				in_mem[i] <= IN_RST_VAL;
			end
		end else if (ce_i) begin
			if (rst_edge) begin
				in_mem[scan_idx] <= cur_lvl & ~TRIG_MASK;
			end
			if (wr_inputs) begin
				in_mem[sel] <= wr_lvl;
			end
		end
	end

	// Constant latched as the trigger is raised by software
	// 32-bit constant
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < NUM_TIMERS; i++) begin
				const_mem[i] <= ZERO32;
			end
		end else if (ce_i && wr_inputs
			&& ((wr_lvl & ~sel_lvl & TRIG_MASK) != '0)) begin
			const_mem[sel] <= const_stage;
		end
	end

	// Timer select and constant staging registers
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sel         <= '0;
			const_stage <= ZERO32;
		end else if (go && avs_write_i) begin
			if (avs_address_i == REG_SELECT) begin
				sel <= sel_word[IDX_W-1:0];
			end
			if (avs_address_i == REG_CONST) begin
				const_stage <= be_merge(const_stage, avs_writedata_i,
					avs_byteenable_i);
			end
		end
	end

	// Answer one cycle after a request is taken; unmapped reads give zero
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= ZERO32;
		end else if (go) begin
			avs_waitrequest_o <= 1'b0;
			if (avs_read_i) begin
				unique case (avs_address_i)
					REG_SELECT:  avs_readdata_o <= {23'h0, sel};
					REG_CONST:   avs_readdata_o <= const_stage;
					REG_INPUTS:  avs_readdata_o <= {26'h0, sel_lvl};
					REG_STATUS: begin
						avs_readdata_o <= ZERO32;
						avs_readdata_o[ST_STATUS] <= stat_mem[sel];
						avs_readdata_o[ST_RUN]    <= run_mem[sel];
						avs_readdata_o[ST_DELAY]  <=
							(mode_mem[sel] == MODE_DLY_ON);
					end
					REG_ELAPSED: avs_readdata_o <= elapsed_mem[sel];
					REG_ACTIVE:  avs_readdata_o <= const_mem[sel];
					default:     avs_readdata_o <= ZERO32;
				endcase
			end
		end else if (ce_i) begin
			avs_waitrequest_o <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks on the scanner
	chk_reset_clears:
	assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(ce_i && rst_edge) |=> (!stat_mem[last_idx] && !run_mem[last_idx]
			&& elapsed_mem[last_idx] == ZERO32))
		else $error("reset edge did not clear timer");

	chk_trig_cleared:
	assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(ce_i && rst_edge) |=> ((in_mem[last_idx] & TRIG_MASK) == '0))
		else $error("triggers not forced low by reset edge");

	chk_oneshot_start:
	assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(ce_i && !rst_edge && !cur_run && start_ok && rise[IN_ONESHOT]
			&& cur_const != ZERO32)
		|=> (stat_mem[last_idx] && run_mem[last_idx]
			&& elapsed_mem[last_idx] == ZERO32))
		else $error("oneshot did not start");

	chk_freeze_count:
	assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(ce_i && cur_run && !cur_lvl[IN_ENABLE] && !rst_edge)
		|=> (elapsed_mem[last_idx] == $past(cur_el)))
		else $error("count moved while disabled");

	chk_oneshot_ignore:
	assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(ce_i && cur_run && cur_mode == MODE_ONESHOT && !rst_edge
			&& ne < cur_const)
		|=> (stat_mem[last_idx] && run_mem[last_idx]))
		else $error("oneshot disturbed while timing");

	chk_delay_low:
	assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(cur_run && cur_mode == MODE_DLY_ON) |-> !cur_stat)
		else $error("delay status high while timing");

	chk_delay_fall:
	assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(ce_i && cur_run && cur_mode == MODE_DLY_ON && fall[IN_DLY_ON]
			&& !rst_edge)
		|=> (!stat_mem[last_idx] && !run_mem[last_idx]
			&& elapsed_mem[last_idx] == $past(cur_el)))
		else $error("early fall did not end delay timing");

	chk_expiry:
	assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(ce_i && cur_run && !rst_edge && ne >= cur_const
			&& !(cur_mode == MODE_DLY_ON && fall[IN_DLY_ON]))
		|=> (!run_mem[last_idx] && elapsed_mem[last_idx] == $past(ne)
			&& stat_mem[last_idx] == ($past(cur_mode) == MODE_DLY_ON)))
		else $error("expiry handled wrongly");

endmodule : plc_timer_array
`default_nettype wire

//--- sim/plc_scan_master.sv
`timescale 1ns/100ps
`default_nettype none
module plc_scan_master (
	input  wire logic        sys_clk_i,
	input  wire logic        wait_i,
	input  wire logic [31:0] rdata_i,
	output logic      [4:0]  addr_o,
	output logic             rd_o,
	output logic             wr_o,
	output logic      [31:0] wdata_o
);
	// Idle bus from time zero
	initial begin
		addr_o  = 5'h00;
		rd_o    = 1'b0;
		wr_o    = 1'b0;
		wdata_o = 32'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// index and constant go out as whole words before a trigger
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		addr_o  <= a;
		wdata_o <= d;
		wr_o    <= 1'b1;
		do @(posedge sys_clk_i); while (wait_i !== 1'b0);
		wr_o    <= 1'b0;
		// Stale data inverted so it never passes for a fresh word
		wdata_o <= ~d;
	endtask : wr

	// Read data is taken at the very edge that sees waitrequest low
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge sys_clk_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		do @(posedge sys_clk_i); while (wait_i !== 1'b0);
		d = rdata_i;
		rd_o   <= 1'b0;
	endtask : rd
endmodule : plc_scan_master
`default_nettype wire

//--- sim/plc_timer_monostable_delayed_on_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module plc_timer_monostable_delayed_on_tb_top import plc_timer_pkg::*; ;
	localparam int TD    = 1024; // Short tick keeps the run small
	localparam int VISIT = 600;  // One scan pass plus a bus answer

	logic        sys_clk_i   = 1'b0;
	logic        nrst_i      = 1'b0;
	logic        ce_i        = 1'b1;
	logic [3:0]  be          = 4'hF;
	logic [4:0]  addr;
	logic        rd;
	logic        wr;
	logic        waitreq;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] v;
	logic [31:0] e1;
	logic [31:0] k;
	logic [8:0]  idx;
	int          err_count   = 0;
	int          checks_done = 0;

	plc_timer_array #(.TICK_DIV(TD)) dut (
		.sys_clk_i        (sys_clk_i),
		.nrst_i           (nrst_i),
		.ce_i             (ce_i),
		.avs_address_i    (addr),
		.avs_read_i       (rd),
		.avs_write_i      (wr),
		.avs_writedata_i  (wdata),
		.avs_byteenable_i (be),
		.avs_readdata_o   (rdata),
		.avs_waitrequest_o(waitreq)
	);

	plc_scan_master bus (
		.sys_clk_i(sys_clk_i),
		.wait_i   (waitreq),
		.rdata_i  (rdata),
		.addr_o   (addr),
		.rd_o     (rd),
		.wr_o     (wr),
		.wdata_o  (wdata)
	);

	// 50 MHz system clock
	always #10 sys_clk_i = ~sys_clk_i;

	////////////////////////////////////////////////////////////////////////
	// One comparison, counted
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s got %h want %h", $time, what,
				got, exp);
		end
	endtask : chk

	// Register read compared under a mask
	task automatic rchk(input logic [4:0] a, input logic [31:0] m,
		input logic [31:0] exp, input string what);
		bus.rd(a, v);
		chk(v & m, exp, what);
	endtask : rchk

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : wt

	task automatic arm(input logic [31:0] c, input logic [31:0] in_v);
		bus.wr(REG_CONST, c);
		bus.wr(REG_INPUTS, in_v);
	endtask : arm

	// Worst wait for a run: whole ticks plus scan lag at both ends
	function automatic int run_cyc(input logic [31:0] ms);
		return int'(ms) * TD + 2 * VISIT;
	endfunction : run_cyc

	// Inputs as they read back after a reset edge
	function automatic logic [31:0] after_reset(input logic [31:0] in_v);
		return in_v & ~{26'h0, TRIG_MASK};
	endfunction : after_reset

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	// Watchdog: the tests need under half of this span
	initial begin
		wt(90000);
		err_count++;
		close_out();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h5D34D899));
		wt(2);
		nrst_i <= 1'b1;
		// Idle timer and bus corners
		idx = 9'($urandom % 500);
		bus.wr(REG_SELECT, {23'h0, idx});
		rchk(REG_INPUTS, 32'h3F, 32'h01, "idle inputs");
		rchk(REG_ELAPSED, '1, 32'h0, "idle elapsed");
		bus.wr(5'h18, $urandom);
		bus.wr(REG_ELAPSED, $urandom);
		rchk(5'h18, '1, 32'h0, "unmapped");
		rchk(REG_ELAPSED, '1, 32'h0, "read-only");
		rchk(REG_SELECT, '1, {23'h0, idx}, "select back");
		// Byte lanes: only the second byte of the staged constant moves
		k = $urandom;
		bus.wr(REG_CONST, k);
		be <= 4'h2;
		bus.wr(REG_CONST, ~k);
		be <= 4'hF;
		rchk(REG_CONST, '1, {k[31:16], ~k[15:8], k[7:0]}, "lanes");
		$display("test defaults done");
		// Oneshot with a late retrigger, then restart and reset edge
		bus.wr(REG_SELECT, {23'h0, idx + 9'h001});
		arm(32'h6, 32'h05);
		wt(VISIT);
		rchk(REG_STATUS, 32'h3, 32'h3, "oneshot run");
		bus.wr(REG_INPUTS, 32'h01);
		wt(3 * TD);
		bus.wr(REG_INPUTS, 32'h05);
		wt(5 * TD + 200);
		rchk(REG_STATUS, 32'h3, 32'h0, "oneshot end");
		rchk(REG_ELAPSED, '1, 32'h6, "oneshot hold");
		bus.wr(REG_INPUTS, 32'h05);
		wt(VISIT);
		rchk(REG_STATUS, 32'h1, 32'h0, "no edge");
		bus.wr(REG_INPUTS, 32'h01);
		wt(VISIT);
		bus.wr(REG_INPUTS, 32'h05);
		wt(VISIT);
		rchk(REG_STATUS, 32'h1, 32'h1, "oneshot again");
		bus.wr(REG_INPUTS, 32'h07);
		wt(VISIT);
		rchk(REG_INPUTS, 32'h3F, after_reset(32'h07), "trig clr");
		rchk(REG_STATUS, 32'h3, 32'h0, "reset status");
		rchk(REG_ELAPSED, '1, 32'h0, "reset count");
		bus.wr(REG_INPUTS, 32'h07);
		wt(VISIT);
		rchk(REG_STATUS, 32'h3, 32'h0, "reset level");
		$display("test oneshot done");
		// Delay-on: expiry, release, early release
		bus.wr(REG_SELECT, {23'h0, 9'($urandom % 500)});
		k = 32'h2 + ($urandom % 3);
		arm(k, 32'h09);
		wt(VISIT);
		rchk(REG_STATUS, 32'h7, 32'h6, "delay timing");
		wt(run_cyc(k));
		rchk(REG_STATUS, 32'h1, 32'h1, "delay expired");
		rchk(REG_ELAPSED, '1, k, "delay hold");
		bus.wr(REG_INPUTS, 32'h01);
		wt(VISIT);
		rchk(REG_STATUS, 32'h1, 32'h0, "delay fall");
		arm(32'h14, 32'h09);
		wt(3 * TD);
		bus.wr(REG_INPUTS, 32'h01);
		wt(VISIT);
		bus.rd(REG_ELAPSED, e1);
		wt(2 * TD);
		rchk(REG_ELAPSED, '1, e1, "early hold");
		rchk(REG_STATUS, 32'h1, 32'h0, "early status");
		chk({31'h0, e1 != 0 && e1 < 5}, 32'h1, "restart");
		$display("test delay_on done");
		// Last timer, largest constant, enable freeze
		bus.wr(REG_SELECT, {23'h0, IDX_LAST});
		arm(32'hFFFFFFFF, 32'h05);
		wt(VISIT);
		rchk(REG_ACTIVE, '1, 32'hFFFFFFFF, "max const");
		wt(2 * TD);
		bus.wr(REG_INPUTS, 32'h04);
		wt(VISIT);
		bus.rd(REG_ELAPSED, e1);
		wt(3 * TD);
		rchk(REG_ELAPSED, '1, e1, "frozen");
		bus.wr(REG_INPUTS, 32'h05);
		wt(2 * TD + VISIT);
		bus.rd(REG_ELAPSED, v);
		chk({31'h0, v > e1}, 32'h1, "resumed");
		rchk(REG_STATUS, 32'h1, 32'h1, "still on");
		// Clock enable low stalls tick and scanner, so time stands still
		bus.rd(REG_ELAPSED, e1);
		ce_i <= 1'b0;
		wt(3 * TD);
		ce_i <= 1'b1;
		bus.rd(REG_ELAPSED, v);
		chk({31'h0, v - e1 <= 32'h1}, 32'h1, "ce hold");
		$display("test freeze done");
		close_out();
	end
endmodule : plc_timer_monostable_delayed_on_tb_top
`default_nettype wire
